// ### hdl/fpp_pkg.sv
/*
 * constants, field positions, reset values and timing counts of the
 * front panel power controller.
 * assumes a 200 MHz aclk and an AXI4-Lite master with 32-bit data.
 */
package fpp_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_IDENT = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // control fields: bits 0..3 are command pulses, 4..8 are stored options
    localparam int CTRL_UP = 0;
    localparam int CTRL_DOWN = 1;
    localparam int CTRL_CYCLE = 2;
    localparam int CTRL_RESET = 3;
    localparam int CTRL_OPT_LSB = 4;
    localparam int CTRL_OPT_W = 5;
    localparam logic [CTRL_OPT_W-1:0] CTRL_OPT_RESET_VAL = 5'h00;
    localparam int OPT_RESTORE = 0;
    localparam int OPT_FORCE_VB = 1;
    localparam int OPT_FORCE_WP = 2;
    localparam int OPT_VB_LOCK = 3;
    localparam int OPT_WP_LOCK = 4;
    // identify fields
    localparam int IDENT_SECS_LSB = 0;
    localparam int IDENT_HAS_PARAM = 8;
    localparam int IDENT_TIMED = 9;
    localparam int IDENT_LED = 10;
    localparam logic [7:0] ID_DEFAULT_SECS = 8'h0F;
    localparam logic [7:0] ID_SECS_RESET_VAL = 8'h00;
    // status fields
    localparam int STAT_POWER = 0;
    localparam int STAT_ID_LED = 1;
    localparam int STAT_AC_GOOD = 2;
    localparam int STAT_LOCK = 3;
    localparam int STAT_SAVED_ON = 4;
    localparam int STAT_VIOL = 5;
    // ------------------------------------------------------------
    // pins and states
    // ------------------------------------------------------------
    localparam int PIN_PWR_BTN = 0;
    localparam int PIN_RST_BTN = 1;
    localparam int PIN_ID_BTN = 2;
    localparam int PIN_SLP_BTN = 3;
    localparam int PIN_SECURE = 4;
    localparam int PIN_RING = 5;
    localparam int PIN_RTC = 6;
    localparam int PIN_OS_DOWN = 7;
    localparam int PIN_AC = 8;
    localparam int PIN_COUNT = 9;
    localparam int BTN_COUNT = 4;
    localparam logic [PIN_COUNT-1:0] PIN_RESET_VAL = 9'h00F;
    typedef enum logic [1:0] {
        PWR_OFF = 2'h0,
        PWR_ON = 2'h1,
        PWR_CYCLE = 2'h3
    } fpp_pwr_t;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_S = 1;
    localparam int DEBOUNCE_MS = 20;
    localparam int RESET_PULSE_MS = 100;
    localparam int CYCLE_OFF_MS = 1000;
    localparam int TICK_CYCLES = TICK_S * 1000000000 / CLK_PERIOD_NS;
    localparam int DEBOUNCE_CYCLES = (DEBOUNCE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_CYCLES = (RESET_PULSE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYCLE_OFF_CYCLES = (CYCLE_OFF_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ### hdl/fpp_front_panel_power_control.sv
/*
 * front panel power, reset, identify and lockout control with an
 * AXI4-Lite register slave.
 * assumes pins arrive asynchronous (buttons active low), watchdog, event
 * filter and boot timer requests are one-cycle pulses on aclk.
 */
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - power cycle on command, watchdog expiry or event filter action
// - power up on button, command, mains restore, rtc wake or ring
// - optionally restore the power state held when mains was lost
// - power down on button unless locked, watchdog, command, filter, os
// - hard reset on unlocked button, command, watchdog or boot timer stage 3
// - status and identify leds work on standby and full power
// - identify state survives power on, off and reset; lost with mains
// - identify led starts off whenever mains is applied
// - command turn-on starts a timeout; another turn-on restarts it
// - timeout defaults to 15 s; parameter gives 1 to 255 s
// - the timeout parameter can switch the led off at once
// - each identify button press toggles the led
// - button turn-on has no timeout
// - powered and locked: power and reset buttons are ignored
// - locked: front panel sleep requests are ignored
// - lockout never blocks power up or wake
// - violation event on power, sleep or reset press while locked
// - options blank video and write protect floppy while locked
// - software may force blank and write protect without lockout
// - supply request high means on, low means off
// - write protect and video blank outputs follow their controls
module fpp_front_panel_power_control #(
    parameter logic [31:0] DEBOUNCE_CYCLES = 32'(fpp_pkg::DEBOUNCE_CYCLES),
    parameter logic [31:0] TICK_CYCLES = 32'(fpp_pkg::TICK_CYCLES),
    parameter logic [31:0] RESET_CYCLES = 32'(fpp_pkg::RESET_CYCLES),
    parameter logic [31:0] CYCLE_OFF_CYCLES = 32'(fpp_pkg::CYCLE_OFF_CYCLES)
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [fpp_pkg::ADDR_W-1:0] s_axil_awaddr,
    input wire logic [2:0] s_axil_awprot,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [fpp_pkg::ADDR_W-1:0] s_axil_araddr,
    input wire logic [2:0] s_axil_arprot,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire logic power_button_n,
    input wire logic reset_button_n,
    input wire logic identify_button_n,
    input wire logic sleep_button_n,
    input wire logic secure_mode_in,
    input wire logic ring_indicate_input,
    input wire logic rtc_wake_request,
    input wire logic os_power_down,
    input wire logic ac_power_good,
    input wire logic wd_power_cycle,
    input wire logic wd_power_down,
    input wire logic wd_hard_reset,
    input wire logic filter_power_cycle,
    input wire logic filter_power_down,
    input wire logic boot_watch_timer_stage3,
    output logic supply_on_request,
    output logic system_reset_out,
    output logic sleep_request,
    output logic lockout_violation,
    output logic video_blank,
    output logic floppy_write_protect,
    output logic identify_led,
    output logic status_led
);
    import fpp_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers and edges
    // ------------------------------------------------------------
    logic [PIN_COUNT-1:0] pin_raw;
    logic [PIN_COUNT-1:0] pin_meta;
    logic [PIN_COUNT-1:0] pin_sync;
    logic [PIN_COUNT-1:0] pin_prev;
    logic [BTN_COUNT-1:0] press;

    assign pin_raw = {ac_power_good, os_power_down, rtc_wake_request, ring_indicate_input, secure_mode_in,
                      sleep_button_n, identify_button_n, reset_button_n, power_button_n};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta <= PIN_RESET_VAL;
            pin_sync <= PIN_RESET_VAL;
            pin_prev <= PIN_RESET_VAL;
        end else if (ce) begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    wire sec = pin_sync[PIN_SECURE];
    wire ac_good = pin_sync[PIN_AC];
    wire ac_rise = pin_sync[PIN_AC] & ~pin_prev[PIN_AC];
    wire ac_fall = ~pin_sync[PIN_AC] & pin_prev[PIN_AC];
    wire ac_edge = ac_rise | ac_fall;
    wire ring_rise = pin_sync[PIN_RING] & ~pin_prev[PIN_RING];
    wire rtc_rise = pin_sync[PIN_RTC] & ~pin_prev[PIN_RTC];
    wire os_rise = pin_sync[PIN_OS_DOWN] & ~pin_prev[PIN_OS_DOWN];

    // ------------------------------------------------------------
    // button debounce
    // ------------------------------------------------------------
    // a level must stand for the whole window before it counts, so bounce
    // shorter than the window never yields a second press
    for (genvar i = 0; i < BTN_COUNT; i++) begin : g_deb
        logic [31:0] cnt;
        logic stable;
        logic stable_d;
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                cnt <= 32'h0000_0000;
                stable <= 1'b1;
                stable_d <= 1'b1;
            end else if (ce) begin
                stable_d <= stable;
                if (pin_sync[i] == stable) begin
                    cnt <= 32'h0000_0000;
                end else if (cnt >= DEBOUNCE_CYCLES - 32'h1) begin
                    cnt <= 32'h0000_0000;
                    stable <= pin_sync[i];
                end else begin
                    cnt <= cnt + 32'h1;
                end
            end
        end
        assign press[i] = stable_d & ~stable;
    end

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    logic [CTRL_OPT_W-1:0] opt;
    logic viol_sticky;
    logic saved_on;
    fpp_pwr_t st;
    fpp_pwr_t next_st;
    logic id_timed;
    logic [7:0] id_secs;

    wire wr_go = ce & s_axil_awvalid & s_axil_wvalid & ~s_axil_bvalid;
    wire rd_go = ce & s_axil_arvalid & ~s_axil_rvalid;
    wire [31:0] wmask = {{8{s_axil_wstrb[3]}}, {8{s_axil_wstrb[2]}}, {8{s_axil_wstrb[1]}}, {8{s_axil_wstrb[0]}}};
    wire [31:0] wm = s_axil_wdata & wmask;
    wire wr_ctrl = wr_go & (s_axil_awaddr == ADDR_CTRL);
    wire wr_ident = wr_go & (s_axil_awaddr == ADDR_IDENT) & s_axil_wstrb[0];
    wire wr_status = wr_go & (s_axil_awaddr == ADDR_STATUS);
    wire wr_mapped = (s_axil_awaddr == ADDR_CTRL) | (s_axil_awaddr == ADDR_IDENT) | (s_axil_awaddr == ADDR_STATUS);
    wire rd_mapped = (s_axil_araddr == ADDR_CTRL) | (s_axil_araddr == ADDR_IDENT) | (s_axil_araddr == ADDR_STATUS);
    wire [CTRL_OPT_W-1:0] opt_wmask = {wmask[CTRL_OPT_LSB+4], wmask[CTRL_OPT_LSB+3:CTRL_OPT_LSB]};
    wire [CTRL_OPT_W-1:0] opt_wdata = s_axil_wdata[CTRL_OPT_LSB+CTRL_OPT_W-1:CTRL_OPT_LSB];

    assign s_axil_awready = wr_go;
    assign s_axil_wready = wr_go;
    assign s_axil_arready = rd_go;

    wire cmd_up = wr_ctrl & wm[CTRL_UP];
    wire cmd_down = wr_ctrl & wm[CTRL_DOWN];
    wire cmd_cycle = wr_ctrl & wm[CTRL_CYCLE];
    wire cmd_reset = wr_ctrl & wm[CTRL_RESET];
    wire viol_clr = wr_status & wm[STAT_VIOL];

    wire [31:0] rd_ctrl = 32'({opt, 4'h0});
    wire [31:0] rd_ident = 32'({identify_led, id_timed, 1'b0, id_secs});
    wire [31:0] rd_status = 32'({viol_sticky, saved_on, sec & (st == PWR_ON), ac_good, identify_led, st != PWR_OFF});
    wire [31:0] rd_mux = (s_axil_araddr == ADDR_CTRL) ? rd_ctrl :
                         (s_axil_araddr == ADDR_IDENT) ? rd_ident :
                         (s_axil_araddr == ADDR_STATUS) ? rd_status : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axil_bvalid <= 1'b0;
            s_axil_bresp <= RESP_OKAY;
            s_axil_rvalid <= 1'b0;
            s_axil_rresp <= RESP_OKAY;
            s_axil_rdata <= 32'h0000_0000;
            opt <= CTRL_OPT_RESET_VAL;
        end else if (ce) begin
            if (wr_go) begin
                s_axil_bvalid <= 1'b1;
                s_axil_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axil_bready) begin
                s_axil_bvalid <= 1'b0;
            end
            if (rd_go) begin
                s_axil_rvalid <= 1'b1;
                s_axil_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
                s_axil_rdata <= rd_mux;
            end else if (s_axil_rready) begin
                s_axil_rvalid <= 1'b0;
            end
            if (wr_ctrl) begin
                opt <= (opt & ~opt_wmask) | (opt_wdata & opt_wmask);
            end
        end
    end

    // ------------------------------------------------------------
    // power sequencing
    // ------------------------------------------------------------
    logic [31:0] cyc_cnt;
    logic [31:0] rst_cnt;
    wire powered = (st == PWR_ON);
    wire lock_active = powered & sec;
    wire restore_up = ac_rise & opt[OPT_RESTORE] & saved_on;
    // the power button always counts in the off state: lockout only guards the on state
    wire up_req = press[PIN_PWR_BTN] | cmd_up | ring_rise | rtc_rise | restore_up;
    wire down_other = wd_power_down | cmd_down | filter_power_down | os_rise;
    wire down_req = (press[PIN_PWR_BTN] & ~sec) | down_other;
    wire cycle_req = cmd_cycle | wd_power_cycle | filter_power_cycle;
    wire rst_req = (press[PIN_RST_BTN] & ~sec) | cmd_reset | wd_hard_reset | boot_watch_timer_stage3;
    wire rst_go = rst_req & powered;
    wire viol = lock_active & (press[PIN_PWR_BTN] | press[PIN_RST_BTN] | press[PIN_SLP_BTN]);

    always_comb begin
        next_st = st;
        case (st)
            PWR_OFF: begin
                if (ac_good && up_req) begin
                    next_st = PWR_ON;
                end
            end
            PWR_ON: begin
                if (!ac_good) begin
                    next_st = PWR_OFF;
                end else if (cycle_req) begin
                    next_st = PWR_CYCLE;
                end else if (down_req) begin
                    next_st = PWR_OFF;
                end
            end
            PWR_CYCLE: begin
                if (!ac_good) begin
                    next_st = PWR_OFF;
                end else if (cyc_cnt >= CYCLE_OFF_CYCLES - 32'h1) begin
                    next_st = PWR_ON;
                end
            end
            default: begin
                next_st = PWR_OFF;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= PWR_OFF;
            supply_on_request <= 1'b0;
            cyc_cnt <= 32'h0000_0000;
            saved_on <= 1'b0;
        end else if (ce) begin
            st <= next_st;
            supply_on_request <= (next_st == PWR_ON);
            cyc_cnt <= (st == PWR_CYCLE) ? cyc_cnt + 32'h1 : 32'h0000_0000;
            if (ac_fall) begin
                saved_on <= (st != PWR_OFF);
            end
        end
    end

    // reset is only meaningful while the system is powered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_cnt <= 32'h0000_0000;
            system_reset_out <= 1'b0;
        end else if (ce) begin
            if (rst_go) begin
                rst_cnt <= RESET_CYCLES - 32'h1;
                system_reset_out <= 1'b1;
            end else if (rst_cnt != 32'h0000_0000) begin
                rst_cnt <= rst_cnt - 32'h1;
            end else begin
                system_reset_out <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // lockout outputs
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sleep_request <= 1'b0;
            lockout_violation <= 1'b0;
            viol_sticky <= 1'b0;
            video_blank <= 1'b0;
            floppy_write_protect <= 1'b0;
            status_led <= 1'b0;
        end else if (ce) begin
            sleep_request <= press[PIN_SLP_BTN] & powered & ~sec;
            lockout_violation <= viol;
            viol_sticky <= viol | (viol_sticky & ~viol_clr);
            video_blank <= opt[OPT_FORCE_VB] | (opt[OPT_VB_LOCK] & lock_active);
            floppy_write_protect <= opt[OPT_FORCE_WP] | (opt[OPT_WP_LOCK] & lock_active);
            status_led <= (next_st != PWR_OFF);
        end
    end

    // ------------------------------------------------------------
    // identify led
    // ------------------------------------------------------------
    logic [31:0] tick_cnt;
    wire tick = (tick_cnt >= TICK_CYCLES - 32'h1);
    wire id_has = wm[IDENT_HAS_PARAM];
    wire [7:0] id_val = wm[IDENT_SECS_LSB+7:IDENT_SECS_LSB];
    wire id_off_cmd = wr_ident & id_has & (id_val == 8'h00);
    wire id_on_cmd = wr_ident & ~id_off_cmd;
    wire [7:0] id_load = id_has ? id_val : ID_DEFAULT_SECS;

    // restarting the tick on each turn-on keeps the timeout exact to a second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt <= 32'h0000_0000;
        end else if (ce) begin
            tick_cnt <= (id_on_cmd || tick) ? 32'h0000_0000 : tick_cnt + 32'h1;
        end
    end

    // held on standby: a mains edge clears it, power state never does
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            identify_led <= 1'b0;
            id_timed <= 1'b0;
            id_secs <= ID_SECS_RESET_VAL;
        end else if (ce) begin
            if (ac_edge) begin
                identify_led <= 1'b0;
                id_timed <= 1'b0;
            end else if (id_off_cmd) begin
                identify_led <= 1'b0;
                id_timed <= 1'b0;
            end else if (id_on_cmd) begin
                identify_led <= 1'b1;
                id_timed <= 1'b1;
                id_secs <= id_load;
            end else if (press[PIN_ID_BTN]) begin
                identify_led <= ~identify_led;
                id_timed <= 1'b0;
            end else if (id_timed && tick) begin
                if (id_secs <= 8'h01) begin
                    identify_led <= 1'b0;
                    id_timed <= 1'b0;
                end else begin
                    id_secs <= id_secs - 8'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_cycle_start;
        ce && powered && ac_good && cycle_req;
    endsequence
    sequence s_rst_start;
        ce && rst_go;
    endsequence

    AST_CYCLE: assert property (s_cycle_start |=> !supply_on_request && st == PWR_CYCLE)
        else $error("power cycle did not drop the supply");
    AST_BTN_UP: assert property (ce && st == PWR_OFF && ac_good && press[PIN_PWR_BTN] |=> supply_on_request)
        else $error("power button did not power up");
    AST_LOCK_DOWN: assert property (ce && powered && sec && ac_good && press[PIN_PWR_BTN] && !cycle_req
        && !down_other |=> supply_on_request)
        else $error("locked power button powered down");
    AST_RESET: assert property (s_rst_start |=> system_reset_out [*2])
        else $error("hard reset pulse too short");
    AST_VIOL: assert property (ce && lock_active && (press[PIN_RST_BTN] || press[PIN_SLP_BTN])
        |=> lockout_violation && viol_sticky)
        else $error("violation not raised");
    AST_SLEEP: assert property (ce && sec && press[PIN_SLP_BTN] |=> !sleep_request)
        else $error("sleep passed while locked");
    AST_ID_TOGGLE: assert property (ce && press[PIN_ID_BTN] && !wr_ident && !ac_edge
        |=> identify_led != $past(identify_led) && !id_timed)
        else $error("identify button did not toggle");
    AST_ID_OFF: assert property (ce && id_off_cmd |=> !identify_led)
        else $error("identify off command ignored");
    AST_ID_ON: assert property (ce && id_on_cmd && !ac_edge |=> identify_led && id_timed && id_secs != 8'h00)
        else $error("identify on command ignored");
    AST_AC_ID: assert property (ce && ac_rise |=> !identify_led)
        else $error("identify not cleared on mains");
    AST_VB: assert property (ce && opt[OPT_FORCE_VB] |=> video_blank)
        else $error("forced blank missing");
    AST_WP: assert property (ce && opt[OPT_WP_LOCK] && lock_active |=> floppy_write_protect)
        else $error("write protect missing under lockout");
    AST_RESTORE: assert property (ce && st == PWR_OFF && restore_up |=> supply_on_request)
        else $error("mains restore did not power up");
endmodule

`default_nettype wire

// ### verification/fpp_panel_model.sv
/*
 * far side of the front panel: push-buttons and the mains sense line.
 * assumes the bench calls its tasks from the aclk domain.
 */
`timescale 1ns/100ps
`default_nettype none
module fpp_panel_model (
    input wire logic aclk,
    output logic [3:0] btn_n,
    output logic ac_good
);
    initial begin
        btn_n = 4'hF;
        ac_good = 1'b0;
    end
    task automatic set_ac(input logic v);
        @(posedge aclk) ac_good <= v;
    endtask
    // held well past the debounce count, so one press gives one event
    task automatic press(input int i);
        @(posedge aclk) btn_n[i] <= 1'b0;
        repeat (12) @(posedge aclk);
        btn_n[i] <= 1'b1;
        repeat (12) @(posedge aclk);
    endtask
endmodule
`default_nettype wire

// ### verification/fpp_front_panel_power_control_tb.sv
/*
 * self-checking bench: AXI4-Lite tasks, pulse and button stimulus.
 * assumes short counts: debounce 4, tick 20, reset 4, cycle-off 8.
 */
`timescale 1ns/100ps
`default_nettype none
module fpp_front_panel_power_control_tb;
    import fpp_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, secure = 0;
    logic ce = 1, ring = 0, rtc = 0, osd = 0;
    logic awready, wready, bvalid, arready, rvalid, sup, rst_o, slp, viol, vb, wp, id_led, st_led, ac;
    logic [3:0] awaddr = 0, araddr = 0, btn_n, wstrb = 4'hF;
    logic [31:0] wdata = 0, rdata, rd;
    logic [1:0] bresp, rresp;
    logic [5:0] ev = 0;
    int miscompares = 0, n_checks = 0, cyc = 0, n_slp = 0, n_viol = 0, n_rst = 0;
    initial forever #2.5 aclk = ~aclk;
    fpp_panel_model i_fpp_panel_model (.aclk, .btn_n, .ac_good(ac));
    fpp_front_panel_power_control #(.DEBOUNCE_CYCLES(4), .TICK_CYCLES(20), .RESET_CYCLES(4),
        .CYCLE_OFF_CYCLES(8)) i_fpp_front_panel_power_control (.aclk, .aresetn, .ce,
        .s_axil_awaddr(awaddr), .s_axil_awprot(3'h0), .s_axil_awvalid(awvalid), .s_axil_awready(awready),
        .s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid), .s_axil_wready(wready),
        .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready), .s_axil_araddr(araddr),
        .s_axil_arprot(3'h0), .s_axil_arvalid(arvalid), .s_axil_arready(arready), .s_axil_rdata(rdata),
        .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready), .power_button_n(btn_n[0]),
        .reset_button_n(btn_n[1]), .identify_button_n(btn_n[2]), .sleep_button_n(btn_n[3]),
        .secure_mode_in(secure), .ring_indicate_input(ring), .rtc_wake_request(rtc),
        .os_power_down(osd), .ac_power_good(ac), .wd_power_cycle(ev[0]), .wd_power_down(ev[1]),
        .wd_hard_reset(ev[2]), .filter_power_cycle(ev[3]), .filter_power_down(ev[4]),
        .boot_watch_timer_stage3(ev[5]), .supply_on_request(sup), .system_reset_out(rst_o),
        .sleep_request(slp), .lockout_violation(viol), .video_blank(vb), .floppy_write_protect(wp),
        .identify_led(id_led), .status_led(st_led));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // a hang in any wait below is cut short here
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        n_slp <= n_slp + slp;
        n_viol <= n_viol + viol;
        n_rst <= n_rst + rst_o;
        if (cyc == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk) {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        do @(posedge aclk); while (!(awready && wready));
        {awvalid, wvalid} <= 2'b00;
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rdr(input logic [3:0] a);
        @(posedge aclk) {araddr, arvalid, rready} <= {a, 2'b11};
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rd = rdata;
        rready <= 1'b0;
    endtask
    task automatic pulse(input int i);
        @(posedge aclk) ev[i] <= 1'b1;
        @(posedge aclk) ev[i] <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(ADDR_CTRL); chk("ctrl reset", rd, 32'h0);
        i_fpp_panel_model.set_ac(1'b1);
        repeat (6) @(posedge aclk);
        rdr(4'hC); chk("unmapped", {30'h0, rresp}, {30'h0, RESP_SLVERR});
        i_fpp_panel_model.press(PIN_PWR_BTN); chk("button up", {st_led, sup}, 2'b11);
        pulse(0); chk("cycle off", sup, 1'b0);
        repeat (15) @(posedge aclk); chk("cycle on", sup, 1'b1);
        pulse(5); chk("reset", rst_o, 1'b1);
        repeat (8) @(posedge aclk); chk("reset end", rst_o, 1'b0);
        secure <= 1'b1;
        repeat (5) @(posedge aclk);
        i_fpp_panel_model.press(PIN_PWR_BTN); chk("locked", sup, 1'b1);
        i_fpp_panel_model.press(PIN_SLP_BTN); chk("slp locked", n_slp, 0);
        i_fpp_panel_model.press(PIN_RST_BTN); chk("rst locked", n_rst, 4);
        chk("viol", n_viol, 3);
        rdr(ADDR_STATUS); chk("status", rd, 32'h2D);
        wr(ADDR_CTRL, 32'h80); repeat (3) @(posedge aclk); chk("blank", vb, 1'b1);
        secure <= 1'b0;
        wr(ADDR_CTRL, 32'h40); repeat (6) @(posedge aclk); chk("wp", {vb, wp}, 2'b01);
        i_fpp_panel_model.press(PIN_SLP_BTN); chk("sleep", n_slp, 1);
        i_fpp_panel_model.press(PIN_RST_BTN); chk("rst btn", n_rst, 8);
        wr(ADDR_STATUS, 32'h20); chk("bresp", bresp, RESP_OKAY);
        rdr(ADDR_STATUS); chk("viol clr", rd, 32'h5);
        wr(ADDR_IDENT, 32'h102); chk("id on", id_led, 1'b1);
        rdr(ADDR_IDENT); chk("id read", rd, 32'h602);
        ce <= 1'b0;
        repeat (60) @(posedge aclk); chk("id frozen", id_led, 1'b1);
        ce <= 1'b1;
        repeat (45) @(posedge aclk); chk("id timed", id_led, 1'b0);
        wr(ADDR_IDENT, 32'h0); repeat (100) @(posedge aclk); chk("id default", id_led, 1'b1);
        wr(ADDR_IDENT, 32'h100); chk("id off", id_led, 1'b0);
        wstrb <= 4'hE;
        wr(ADDR_IDENT, 32'h0); chk("id lane", id_led, 1'b0);
        wstrb <= 4'hF;
        i_fpp_panel_model.press(PIN_ID_BTN);
        repeat (400) @(posedge aclk); chk("id button", id_led, 1'b1);
        pulse(4); chk("down", sup, 1'b0);
        chk("id kept", id_led, 1'b1);
        ring <= 1'b1;
        repeat (6) @(posedge aclk); chk("ring up", sup, 1'b1);
        osd <= 1'b1;
        repeat (6) @(posedge aclk); chk("os down", sup, 1'b0);
        rtc <= 1'b1;
        repeat (6) @(posedge aclk); chk("rtc up", sup, 1'b1);
        i_fpp_panel_model.set_ac(1'b0);
        repeat (6) @(posedge aclk); chk("ac id", id_led, 1'b0);
        wr(ADDR_CTRL, 32'h10);
        i_fpp_panel_model.set_ac(1'b1);
        repeat (6) @(posedge aclk); chk("restore", sup, 1'b1);
        pulse(2); chk("wd reset", rst_o, 1'b1);
        wr(ADDR_CTRL, 32'h8); chk("cmd reset", rst_o, 1'b1);
        wr(ADDR_CTRL, 32'h4); chk("cmd cycle", sup, 1'b0);
        repeat (15) @(posedge aclk); chk("back on", sup, 1'b1);
        pulse(3); chk("filter cycle", sup, 1'b0);
        repeat (15) @(posedge aclk);
        pulse(1); chk("wd down", sup, 1'b0);
        wr(ADDR_CTRL, 32'h1); chk("cmd up", sup, 1'b1);
        wr(ADDR_CTRL, 32'h2); chk("cmd down", sup, 1'b0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
